// [verilog/motor_axis_calib_watchdog.sv]
// supervisory logic of a two-axis motor board: index capture, diagnostics
// What this block does
// - port b bit 4 set enters calibration mode for index capture at speed
// - in calibration an index pulse captures the count and flags host
// - capture flags read on port c bit 1 (axis 1) and bit 3 (axis 2)
// - later index pulses are never locked out; each recaptures the count
// - port b bit 1 set loops converter outputs back to inputs
// - synthetic a, b, index from port a bits 5 to 7 feed both axes
// - port b bit 0 clear selects synthetic encoder, set passes real ones
// - fault alarm line goes high when setpoints are not refreshed
// - per-axis retriggerable heartbeat, restarted by a setpoint write, 50 ms
// - heartbeat state on port c bit 0 and bit 2, one means healthy
// - after reset the alarm stands until every converter was written once
// - disabled axis: heartbeat ignored for alarm, current drive grounded
// - configuration decides if converters obey the software latch
// - configuration routes sample clock to one of three dma request lines
// - port b bit 4 clear holds capture flags clear; set arms next index
// - external sample clock latches converters only while port b bit 2 is one; dma routing ignores the bit
`timescale 1ns/1ps
module motor_axis_calib_watchdog
  import motor_axis_pkg::*;
#(
  parameter int unsigned HEARTBEAT_HOLD = HEARTBEAT_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SERVO_SAMPLE_CLOCK,
  input wire logic [1:0] JOINT_ENC_A,
  input wire logic [1:0] JOINT_ENC_B,
  input wire logic [1:0] JOINT_ENC_I,
  input wire logic [1:0] AXIS_ENABLE,
  output logic [1:0] ENCODER_COUNT_INTERFACE_A,
  output logic [1:0] ENCODER_COUNT_INTERFACE_B,
  output logic [1:0] ENCODER_COUNT_INTERFACE_I,
  output logic [2:0] ENCODER_MODE,
  output logic [23:0] DAC_CODE,
  output logic CONVERT_LATCH,
  output logic LOOPBACK_RELAY,
  output logic [1:0] DRIVE_GROUND,
  output logic FAULT_ALARM_LINE,
  output logic [2:0] DRQ_LINES,
  output logic [4:0] IRQ_LINES,
  output logic [1:0] AXIS_ALIVE_INDICATOR,
  output logic [1:0] AXIS_USER_INDICATOR
);

  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    logic sclk_prev;
    logic [1:0] a_prev;
    logic [1:0] b_prev;
    logic [1:0] i_prev;
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [5:0] config_bits;
    logic [DAC_W-1:0] dac1;
    logic [DAC_W-1:0] dac2;
    logic [1:0] captured;
    logic [COUNT_W-1:0] count1;
    logic [COUNT_W-1:0] count2;
    logic [COUNT_W-1:0] capture1;
    logic [COUNT_W-1:0] capture2;
    apb_rsp_t rsp;
    logic [1:0] enc_a_out;
    logic [1:0] enc_b_out;
    logic [1:0] enc_i_out;
    logic [23:0] dac_out;
    logic latch_out;
    logic fault;
    logic [2:0] drq;
    logic [4:0] irq;
    logic [1:0] alive_out;
    logic [1:0] ground;
  } top_t;

  top_t cur;
  top_t next_cur;
  pins_t pins_raw;
  logic [1:0] alive;
  logic [1:0] hb_kick;

  assign pins_raw = '{sample_clock: SERVO_SAMPLE_CLOCK, enc_a: JOINT_ENC_A,
                      enc_b: JOINT_ENC_B, enc_i: JOINT_ENC_I,
                      axis_enable: AXIS_ENABLE};

  // one one-shot per axis; kicked by a setpoint write on the bus
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++)
    begin : gen_hb
      axis_heartbeat #(
        .HOLD_CYCLES(HEARTBEAT_HOLD)
      ) u_hb (
        .clock(CLOCK),
        .resetn(RESETN),
        .kick(hb_kick[g]),
        .alive(alive[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic wr;
    logic setup;
    logic [1:0] sel_a;
    logic [1:0] sel_b;
    logic [1:0] sel_i;
    logic [1:0] idx_rise;
    logic [1:0] up;
    logic [1:0] step;
    logic sclk_edge;
    logic sw_latch;
    logic dac_latch;
    logic [31:0] rd;
    logic hit;
    wr = 1'b0;
    setup = 1'b0;
    sel_a = '0;
    sel_b = '0;
    sel_i = '0;
    idx_rise = '0;
    up = '0;
    step = '0;
    sclk_edge = 1'b0;
    sw_latch = 1'b0;
    dac_latch = 1'b0;
    rd = '0;
    hit = 1'b0;
    next_cur = cur;
    hb_kick = '0;

    // two flops before anything reads a pin
    next_cur.sync1 = pins_raw;
    next_cur.sync2 = cur.sync1;
    next_cur.sclk_prev = cur.sync2.sample_clock;

    // apb: answer in the access cycle, write lands at that edge
    wr = PSEL & PENABLE & PWRITE & cur.rsp.pready;
    setup = PSEL & ~PENABLE;

    // encoder source: synthetic bits shared by both axes, or the joints
    if (cur.port_b[PB_REAL_ENC_BIT])
    begin
      sel_a = cur.sync2.enc_a;
      sel_b = cur.sync2.enc_b;
      sel_i = cur.sync2.enc_i;
    end
    else
    begin
      sel_a = {2{cur.port_a[PA_SYN_A_BIT]}};
      sel_b = {2{cur.port_a[PA_SYN_B_BIT]}};
      sel_i = {2{cur.port_a[PA_SYN_I_BIT]}};
    end
    next_cur.enc_a_out = sel_a;
    next_cur.enc_b_out = sel_b;
    next_cur.enc_i_out = sel_i;
    next_cur.a_prev = sel_a;
    next_cur.b_prev = sel_b;
    next_cur.i_prev = sel_i;

    // quadrature count per axis; a double step is an illegal jump, dropped
    for (int k = 0; k < NUM_AXES; k++)
    begin
      step[k] = (sel_a[k] ^ cur.a_prev[k]) ^ (sel_b[k] ^ cur.b_prev[k]);
      up[k] = sel_a[k] ^ cur.b_prev[k];
      idx_rise[k] = sel_i[k] & ~cur.i_prev[k];
    end
    if (step[0])
    begin
      next_cur.count1 = up[0] ? cur.count1 + 16'h0001 : cur.count1 - 16'h0001;
    end
    if (step[1])
    begin
      next_cur.count2 = up[1] ? cur.count2 + 16'h0001 : cur.count2 - 16'h0001;
    end

    // calibration capture; motion is left to the host to stop
    if (!cur.port_b[PB_CAL_BIT])
    begin
      next_cur.captured = '0;
    end
    else
    begin
      // every rising index recaptures, nothing is locked out
      if (idx_rise[0])
      begin
        next_cur.capture1 = cur.count1;
        next_cur.captured[0] = 1'b1;
      end
      if (idx_rise[1])
      begin
        next_cur.capture2 = cur.count2;
        next_cur.captured[1] = 1'b1;
      end
    end

    // latch sources
    sclk_edge = cur.sync2.sample_clock & ~cur.sclk_prev
                & cur.port_b[PB_SCLK_EN_BIT];
    sw_latch = wr && (PADDR == OFF_SW_LATCH);
    next_cur.latch_out = sclk_edge | sw_latch;
    dac_latch = sclk_edge
                | (sw_latch & cur.config_bits[CFG_DAC_SW_BIT]);

    // register writes
    if (wr)
    begin
      case (PADDR)
        OFF_PORT_A: next_cur.port_a = PWDATA[7:0];
        OFF_PORT_B: next_cur.port_b = PWDATA[7:0];
        OFF_CONFIG: next_cur.config_bits = PWDATA[5:0];
        OFF_DAC1:
        begin
          next_cur.dac1 = PWDATA[DAC_W-1:0];
          hb_kick[0] = 1'b1;
        end
        OFF_DAC2:
        begin
          next_cur.dac2 = PWDATA[DAC_W-1:0];
          hb_kick[1] = 1'b1;
        end
        default: next_cur.port_a = cur.port_a;
      endcase
    end

    // converter outputs: immediate, or held until a latch in sync mode
    if (!cur.port_b[PB_DAC_SYNC_BIT])
    begin
      next_cur.dac_out = {next_cur.dac2, next_cur.dac1};
    end
    else if (dac_latch)
    begin
      next_cur.dac_out = {cur.dac2, cur.dac1};
    end

    // read mux, prepared in the setup cycle
    hit = 1'b1;
    case (PADDR)
      OFF_PORT_A: rd = {24'h000000, cur.port_a};
      OFF_PORT_B: rd = {24'h000000, cur.port_b};
      OFF_PORT_C: rd = {28'h0000000, cur.captured[1], alive[1],
                        cur.captured[0], alive[0]};
      OFF_CONFIG: rd = {26'h0000000, cur.config_bits};
      OFF_DAC1: rd = {20'h00000, cur.dac1};
      OFF_DAC2: rd = {20'h00000, cur.dac2};
      OFF_SW_LATCH: rd = '0;
      OFF_CAPTURE1: rd = {16'h0000, cur.capture1};
      OFF_CAPTURE2: rd = {16'h0000, cur.capture2};
      OFF_COUNT1: rd = {16'h0000, cur.count1};
      OFF_COUNT2: rd = {16'h0000, cur.count2};
      default: hit = 1'b0;
    endcase
    next_cur.rsp.pready = setup;
    next_cur.rsp.pslverr = setup & (~hit | (PADDR[1:0] != 2'b00));
    next_cur.rsp.prdata = (setup & ~PWRITE & hit) ? rd : 32'h00000000;

    // alarm: a disabled axis is left out of the vote
    next_cur.alive_out = alive;
    next_cur.fault = |(~alive & cur.sync2.axis_enable);
    next_cur.ground = ~cur.sync2.axis_enable;

    // jumper style routing of the sample clock and the alarm
    next_cur.drq = '0;
    case (drq_sel_t'(cur.config_bits[CFG_DRQ_LSB +: 2]))
      DRQ_LINE1: next_cur.drq[0] = cur.sync2.sample_clock;
      DRQ_LINE2: next_cur.drq[1] = cur.sync2.sample_clock;
      DRQ_LINE3: next_cur.drq[2] = cur.sync2.sample_clock;
      default: next_cur.drq = '0;
    endcase
    next_cur.irq = '0;
    case (irq_sel_t'(cur.config_bits[CFG_IRQ_LSB +: 3]))
      IRQ_LINE3: next_cur.irq[0] = cur.fault;
      IRQ_LINE4: next_cur.irq[1] = cur.fault;
      IRQ_LINE5: next_cur.irq[2] = cur.fault;
      IRQ_LINE6: next_cur.irq[3] = cur.fault;
      IRQ_LINE7: next_cur.irq[4] = cur.fault;
      default: next_cur.irq = '0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cur <= '0;
      cur.port_a <= PORT_A_RESET;
      cur.port_b <= PORT_B_RESET;
      cur.config_bits <= CONFIG_RESET[5:0];
      cur.dac1 <= DAC_RESET;
      cur.dac2 <= DAC_RESET;
      cur.dac_out <= {DAC_RESET, DAC_RESET};
      cur.fault <= 1'b1;
      cur.sync1.axis_enable <= '1;
      cur.sync2.axis_enable <= '1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign PRDATA = cur.rsp.prdata;
  assign PREADY = cur.rsp.pready;
  assign PSLVERR = cur.rsp.pslverr;
  assign ENCODER_COUNT_INTERFACE_A = cur.enc_a_out;
  assign ENCODER_COUNT_INTERFACE_B = cur.enc_b_out;
  assign ENCODER_COUNT_INTERFACE_I = cur.enc_i_out;
  assign ENCODER_MODE = cur.port_a[PA_ENC_MODE_LSB +: 3];
  assign DAC_CODE = cur.dac_out;
  assign CONVERT_LATCH = cur.latch_out;
  // relay closes the loop while the bit is set; host allows settling
  assign LOOPBACK_RELAY = cur.port_b[PB_LOOPBACK_BIT];
  assign DRIVE_GROUND = cur.ground;
  assign FAULT_ALARM_LINE = cur.fault;
  assign DRQ_LINES = cur.drq;
  assign IRQ_LINES = cur.irq;
  assign AXIS_ALIVE_INDICATOR = cur.alive_out;
  assign AXIS_USER_INDICATOR = {cur.port_a[PA_USER2_BIT],
                                cur.port_a[PA_USER1_BIT]};

endmodule

// [pkg/motor_axis_pkg.sv]
// constants, register map and carrier types for the motor axis supervisor
package motor_axis_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] OFF_PORT_A = 8'h00;
  localparam logic [7:0] OFF_PORT_B = 8'h04;
  localparam logic [7:0] OFF_PORT_C = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0c;
  localparam logic [7:0] OFF_DAC1 = 8'h10;
  localparam logic [7:0] OFF_DAC2 = 8'h14;
  localparam logic [7:0] OFF_SW_LATCH = 8'h18;
  localparam logic [7:0] OFF_CAPTURE1 = 8'h1c;
  localparam logic [7:0] OFF_CAPTURE2 = 8'h20;
  localparam logic [7:0] OFF_COUNT1 = 8'h24;
  localparam logic [7:0] OFF_COUNT2 = 8'h28;

  // port a fields
  localparam int PA_ENC_MODE_LSB = 0;
  localparam int PA_USER1_BIT = 3;
  localparam int PA_USER2_BIT = 4;
  localparam int PA_SYN_A_BIT = 5;
  localparam int PA_SYN_B_BIT = 6;
  localparam int PA_SYN_I_BIT = 7;
  // port b fields
  localparam int PB_REAL_ENC_BIT = 0;
  localparam int PB_LOOPBACK_BIT = 1;
  localparam int PB_SCLK_EN_BIT = 2;
  localparam int PB_DAC_SYNC_BIT = 3;
  localparam int PB_CAL_BIT = 4;
  // port c fields
  localparam int PC_ALIVE1_BIT = 0;
  localparam int PC_CAPT1_BIT = 1;
  localparam int PC_ALIVE2_BIT = 2;
  localparam int PC_CAPT2_BIT = 3;
  // config fields
  localparam int CFG_DAC_SW_BIT = 0;
  localparam int CFG_DRQ_LSB = 1;
  localparam int CFG_IRQ_LSB = 3;

  // reset values
  localparam logic [7:0] PORT_A_RESET = 8'h00;
  localparam logic [7:0] PORT_B_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  localparam logic [11:0] DAC_RESET = 12'h800;

  // timing
  localparam int CLOCK_MHZ = 250;
  localparam int HEARTBEAT_MS = 50;
  localparam int HEARTBEAT_CYCLES = HEARTBEAT_MS * CLOCK_MHZ * 1000;

  localparam int NUM_AXES = 2;
  localparam int COUNT_W = 16;
  localparam int DAC_W = 12;
  localparam int HB_W = 24;

  // synchronised pin bundle
  typedef struct packed {
    logic sample_clock;
    logic [NUM_AXES-1:0] enc_a;
    logic [NUM_AXES-1:0] enc_b;
    logic [NUM_AXES-1:0] enc_i;
    logic [NUM_AXES-1:0] axis_enable;
  } pins_t;

  // apb request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [1:0]
  {
    DRQ_LINE1 = 2'b00,
    DRQ_LINE2 = 2'b01,
    DRQ_LINE3 = 2'b10
  } drq_sel_t;

  typedef enum logic [2:0]
  {
    IRQ_LINE3 = 3'b000,
    IRQ_LINE4 = 3'b001,
    IRQ_LINE5 = 3'b010,
    IRQ_LINE6 = 3'b011,
    IRQ_LINE7 = 3'b100
  } irq_sel_t;

  typedef enum logic
  {
    HB_EXPIRED = 1'b0,
    HB_RUNNING = 1'b1
  } hb_state_t;

endpackage

// [verilog/axis_heartbeat.sv]
// retriggerable one-shot that shows whether an axis setpoint is fresh
`timescale 1ns/1ps
module axis_heartbeat
  import motor_axis_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HEARTBEAT_CYCLES
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic kick,
  output logic alive
);

  typedef struct packed {
    hb_state_t mode;
    logic [HB_W-1:0] remain;
  } hb_t;

  localparam logic [HB_W-1:0] HOLD = HOLD_CYCLES[HB_W-1:0];

  hb_t cur;
  hb_t next_cur;

  // starts expired so the alarm stands until the first write
  always_comb
  begin
    next_cur = cur;
    if (kick)
    begin
      next_cur.mode = HB_RUNNING;
      next_cur.remain = HOLD;
    end
    else
    begin
      case (cur.mode)
        HB_RUNNING:
        begin
          if (cur.remain <= 24'h000001)
          begin
            next_cur.mode = HB_EXPIRED;
            next_cur.remain = '0;
          end
          else
          begin
            next_cur.remain = cur.remain - 24'h000001;
          end
        end
        default:
        begin
          next_cur.mode = HB_EXPIRED;
          next_cur.remain = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cur <= '{mode: HB_EXPIRED, remain: '0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign alive = (cur.mode == HB_RUNNING);

endmodule

// [test/axis_supervisor_monitor.sv]
// port-level assertions for the motor axis supervisor
`timescale 1ns/1ps
module axis_supervisor_monitor
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SERVO_SAMPLE_CLOCK,
  input wire logic [1:0] AXIS_ENABLE,
  input wire logic CONVERT_LATCH,
  input wire logic [1:0] DRIVE_GROUND,
  input wire logic FAULT_ALARM_LINE,
  input wire logic [2:0] DRQ_LINES,
  input wire logic [4:0] IRQ_LINES,
  input wire logic [1:0] AXIS_ALIVE_INDICATOR
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  AST_READY_AFTER_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  AST_READY_IN_ACCESS: assert property (PREADY |-> PENABLE && !$past(PENABLE))
    else $error("ready outside access cycle");
  AST_ERR_ZERO_DATA: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error without ready or with data");
  AST_IRQ_FOLLOWS_ALARM: assert property (1'b1 |=>
    ((IRQ_LINES != 5'h00) == $past(FAULT_ALARM_LINE)))
    else $error("interrupt line does not follow alarm");
  AST_IRQ_ONE_LINE: assert property ($onehot0(IRQ_LINES))
    else $error("alarm on several interrupt lines");
  AST_DRQ_FOLLOWS_CLOCK: assert property (1'b1 |-> ##3
    ((DRQ_LINES != 3'h0) == $past(SERVO_SAMPLE_CLOCK, 3)))
    else $error("request line does not follow sample clock");
  AST_DRQ_ONE_LINE: assert property ($onehot0(DRQ_LINES))
    else $error("sample clock on several request lines");
  AST_GROUND_FOLLOWS_SWITCH: assert property (1'b1 |-> ##3
    (DRIVE_GROUND == ~$past(AXIS_ENABLE, 3)))
    else $error("drive ground does not follow switch");
  AST_ALARM_ON_EXPIRY: assert property
    (((~AXIS_ALIVE_INDICATOR & ~DRIVE_GROUND) != 2'b00) [*2] |-> FAULT_ALARM_LINE)
    else $error("expired enabled axis without alarm");
  AST_NO_ALARM_WHEN_ALIVE: assert property
    ((AXIS_ALIVE_INDICATOR == 2'b11) [*2] |-> !FAULT_ALARM_LINE)
    else $error("alarm while both axes alive");
  AST_LATCH_PULSE: assert property (CONVERT_LATCH |=> !CONVERT_LATCH)
    else $error("latch pulse longer than one cycle");

  COV_ALARM_CLEARED: cover property ($fell(FAULT_ALARM_LINE));
  COV_SLAVE_ERROR: cover property (PSLVERR);
  COV_LATCH: cover property (CONVERT_LATCH);
endmodule

bind motor_axis_calib_watchdog axis_supervisor_monitor u_mon
(
  .CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SERVO_SAMPLE_CLOCK(SERVO_SAMPLE_CLOCK), .AXIS_ENABLE(AXIS_ENABLE),
  .CONVERT_LATCH(CONVERT_LATCH), .DRIVE_GROUND(DRIVE_GROUND),
  .FAULT_ALARM_LINE(FAULT_ALARM_LINE), .DRQ_LINES(DRQ_LINES),
  .IRQ_LINES(IRQ_LINES), .AXIS_ALIVE_INDICATOR(AXIS_ALIVE_INDICATOR)
);

// [test/host_backplane_model.sv]
// host side of the backplane: servo sample clock source
`timescale 1ns/1ps
module host_backplane_model
#(
  parameter int HALF = 4
)
(
  input wire logic clock,
  input wire logic run,
  output logic sample_clock
);
  int count = 0;

  initial sample_clock = 1'b0;

  // toggles every HALF clocks while run is high; it does not restart the heartbeat
  always @(posedge clock)
  begin
    if (!run)
    begin
      count <= 0;
      sample_clock <= 1'b0;
    end
    else if (count == HALF - 1)
    begin
      count <= 0;
      sample_clock <= ~sample_clock;
    end
    else
      count <= count + 1;
  end
endmodule

// [test/tb_top.sv]
// self-checking bench for the motor axis supervisor
`timescale 1ns/1ps
module tb_top;
  import motor_axis_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata, c1;
  logic pready, pslverr, rerr, sclk, latch, relay, fault;
  logic sclk_run = 1'b0;
  logic [1:0] enc_a = 2'b00;
  logic [1:0] enc_b = 2'b00;
  logic [1:0] enc_i = 2'b00;
  logic [1:0] axis_en = 2'b11;
  logic [1:0] quad = 2'b00;
  logic [1:0] out_a, out_b, out_i, ground, alive, user;
  logic [2:0] mode, drq;
  logic [4:0] irq;
  logic [23:0] dac;
  int fails = 0;
  int num_checks = 0;

  always #2 clock = ~clock;

  host_backplane_model #(.HALF(4)) u_host
    (.clock(clock), .run(sclk_run), .sample_clock(sclk));

  motor_axis_calib_watchdog #(.HEARTBEAT_HOLD(50)) u_dut
  (
    .CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SERVO_SAMPLE_CLOCK(sclk),
    .JOINT_ENC_A(enc_a), .JOINT_ENC_B(enc_b), .JOINT_ENC_I(enc_i),
    .AXIS_ENABLE(axis_en), .ENCODER_COUNT_INTERFACE_A(out_a),
    .ENCODER_COUNT_INTERFACE_B(out_b), .ENCODER_COUNT_INTERFACE_I(out_i),
    .ENCODER_MODE(mode), .DAC_CODE(dac), .CONVERT_LATCH(latch),
    .LOOPBACK_RELAY(relay), .DRIVE_GROUND(ground), .FAULT_ALARM_LINE(fault),
    .DRQ_LINES(drq), .IRQ_LINES(irq), .AXIS_ALIVE_INDICATOR(alive),
    .AXIS_USER_INDICATOR(user)
  );

  task automatic give_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // setup one cycle, then hold until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask

  task automatic step(input int n);
    repeat (n)
    begin
      quad = quad + 2'd1;
      enc_a <= {2{quad[1]}};
      enc_b <= {2{quad[1] ^ quad[0]}};
      cyc(4);
    end
  endtask

  task automatic index_pulse();
    enc_i <= 2'b11;
    cyc(4);
    enc_i <= 2'b00;
    cyc(4);
  endtask

  task automatic t_reset();
    chk(fault, 1);
    chk(relay, 0);
    chk(dac, 24'h800800);
    rd(OFF_PORT_A, 32'hff, 32'h00);
    rd(OFF_PORT_B, 32'hff, 32'h00);
    rd(OFF_CONFIG, 32'hff, 32'h01);
    rd(OFF_PORT_C, 32'hff, 32'h00);
    apb(1'b0, 8'h2c, 32'h0);
    chk({rerr, rdata[30:0]}, 32'h80000000);
  endtask

  task automatic t_encoder();
    wr(OFF_PORT_A, 32'ha0);
    cyc(3);
    chk({out_a, out_b, out_i}, 6'b110011);
    wr(OFF_PORT_A, 32'h5d);
    cyc(3);
    chk({out_a, out_b, out_i, user}, 8'h33);
    chk(mode, 3'h5);
    enc_a <= 2'b01;
    enc_b <= 2'b10;
    wr(OFF_PORT_B, 32'h03);
    cyc(6);
    chk({out_a, out_b, out_i}, 6'b011000);
    chk(relay, 1);
    enc_a <= 2'b00;
    enc_b <= 2'b00;
  endtask

  task automatic t_heartbeat();
    wr(OFF_DAC1, 32'h123);
    cyc(4);
    chk({fault, dac[11:0]}, 13'h1123);
    wr(OFF_DAC2, 32'h456);
    cyc(4);
    chk(fault, 0);
    rd(OFF_PORT_C, 32'h5, 32'h5);
    repeat (3)
    begin
      cyc(30);
      wr(OFF_DAC1, 32'h123);
      wr(OFF_DAC2, 32'h456);
    end
    chk(fault, 0);
    cyc(44);
    chk(alive, 2'b11);
    cyc(12);
    chk(alive, 2'b00);
    cyc(2);
    chk(fault, 1);
    rd(OFF_PORT_C, 32'h5, 32'h0);
  endtask

  task automatic t_disable();
    axis_en <= 2'b01;
    cyc(5);
    chk(ground, 2'b10);
    wr(OFF_DAC1, 32'h123);
    cyc(4);
    chk(fault, 0);
    axis_en <= 2'b11;
    cyc(60);
    chk({fault, ground}, 3'b100);
  endtask

  task automatic t_routing();
    int n;
    sclk_run <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wr(OFF_CONFIG, i * 8 + (i % 3) * 2 + 1);
      cyc(2);
      n = 0;
      while (drq === 3'b000 && n < 40)
      begin
        @(posedge clock);
        n++;
      end
      chk(drq, 1 << (i % 3));
      chk(irq, 1 << i);
    end
    sclk_run <= 1'b0;
    wr(OFF_CONFIG, 32'h01);
  endtask

  task automatic t_latch();
    wr(OFF_PORT_B, 32'h0b);
    wr(OFF_DAC1, 32'h321);
    cyc(3);
    chk(dac[11:0], 12'h123);
    wr(OFF_SW_LATCH, 32'h0);
    cyc(1);
    chk(latch, 1);
    cyc(2);
    chk(dac[11:0], 12'h321);
    wr(OFF_CONFIG, 32'h00);
    wr(OFF_DAC1, 32'h654);
    wr(OFF_SW_LATCH, 32'h0);
    cyc(3);
    chk(dac[11:0], 12'h321);
    sclk_run <= 1'b1;
    cyc(30);
    chk(dac[11:0], 12'h321);
    wr(OFF_PORT_B, 32'h0f);
    cyc(30);
    chk(dac[11:0], 12'h654);
    sclk_run <= 1'b0;
    wr(OFF_CONFIG, 32'h01);
  endtask

  task automatic t_index();
    wr(OFF_PORT_B, 32'h13);
    rd(OFF_PORT_C, 32'ha, 32'h0);
    step(5);
    index_pulse();
    rd(OFF_PORT_C, 32'ha, 32'ha);
    apb(1'b0, OFF_COUNT2, 32'h0);
    rd(OFF_CAPTURE2, 32'hffff, rdata);
    step(3);
    // axis is halted by the host before the index is read back
    apb(1'b0, OFF_COUNT1, 32'h0);
    c1 = rdata;
    index_pulse();
    rd(OFF_CAPTURE1, 32'hffff, c1);
    wr(OFF_PORT_B, 32'h03);
    rd(OFF_PORT_C, 32'ha, 32'h0);
    index_pulse();
    rd(OFF_PORT_C, 32'ha, 32'h0);
  endtask

  initial
  begin
    cyc(8);
    resetn <= 1'b1;
    t_reset();
    t_encoder();
    t_heartbeat();
    t_disable();
    t_routing();
    t_latch();
    t_index();
    give_verdict();
  end
endmodule
